// ==== rtl/srfb_params.svh ====
// register map and field constants for the segment flag bank
`ifndef SRFB_PARAMS_SVH
`define SRFB_PARAMS_SVH

`define SRFB_ADDR_W 16
`define SRFB_DATA_W 32
`define SRFB_SEGS 128
`define SRFB_WORDS 4
`define SRFB_SEG_BYTES 16
`define SRFB_OFS_IRQ_EN 16'h8f80
`define SRFB_OFS_CKSUM 16'h8fa0
`define SRFB_OFS_OVFL 16'h8fc0
`define SRFB_OFS_RXFLAG 16'h8fe0
`define SRFB_OFS_CTRL 16'h8ff0
`define SRFB_OFS_IRQ_STAT 16'h8ff4
`define SRFB_OFS_IRQ_MASK 16'h8ff8
`define SRFB_CTRL_GIE_BIT 0
`define SRFB_EV_RX_BIT 0
`define SRFB_EV_OVFL_BIT 1
`define SRFB_EV_CKSUM_BIT 2
`define SRFB_EV_W 3
`define SRFB_RST_WORD 32'h0000_0000
`define SRFB_RST_EV 3'h0

`endif

// ==== rtl/srfb_pkg.sv ====
// types shared by the segment flag bank
`default_nettype none
package srfb_pkg;

  typedef logic [127:0] srfb_seg_vec_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [31:0] wdata;
  } srfb_bus_req_t;

  typedef struct packed {
    logic [127:0] rx;
    logic [127:0] cksum_err;
  } srfb_seg_evt_t;

endpackage : srfb_pkg
`default_nettype wire

// ==== rtl/srfb_flag_bank.sv ====
// per-segment receive, overflow, checksum flags and interrupt enables
// =====================================================================
`include "srfb_params.svh"
`default_nettype none
module srfb_flag_bank (
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  input wire logic [15:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [31:0] O_RDATA,
  input wire logic [127:0] I_SEG_RX,
  input wire logic [127:0] I_SEG_CKSUM_ERR,
  output logic [127:0] O_SEG_PENDING,
  output logic O_BUF_IRQ,
  output logic O_IRQ
);

  // =====================================================================
  // request bundling
  srfb_pkg::srfb_bus_req_t req;
  srfb_pkg::srfb_seg_evt_t evt;
  assign req = '{wr: I_WR, rd: I_RD, addr: I_ADDR, wdata: I_WDATA};
  assign evt = '{rx: I_SEG_RX, cksum_err: I_SEG_CKSUM_ERR};

  // word w bit 31-k maps to segment 32*w+k
  function automatic srfb_pkg::srfb_seg_vec_t word_to_seg(
    input logic [31:0] d,
    input logic [1:0] w
  );
    srfb_pkg::srfb_seg_vec_t v;
    v = '0;
    for (int k = 0; k < 32; k++) begin
      v[{w, 5'(k)}] = d[31 - k];
    end
    return v;
  endfunction : word_to_seg

  function automatic logic [31:0] seg_to_word(
    input srfb_pkg::srfb_seg_vec_t v,
    input logic [1:0] w
  );
    logic [31:0] d;
    d = '0;
    for (int k = 0; k < 32; k++) begin
      d[31 - k] = v[{w, 5'(k)}];
    end
    return d;
  endfunction : seg_to_word

  // =====================================================================
  // address decode
  logic [1:0] word_sel;
  logic hit_en, hit_ck, hit_ov, hit_rx, hit_ctrl, hit_stat, hit_mask;
  assign word_sel = req.addr[3:2];
  assign hit_en = (req.addr[15:4] == 12'(`SRFB_OFS_IRQ_EN >> 4)) &
    (req.addr[1:0] == 2'h0);
  assign hit_ck = (req.addr[15:4] == 12'(`SRFB_OFS_CKSUM >> 4)) &
    (req.addr[1:0] == 2'h0);
  assign hit_ov = (req.addr[15:4] == 12'(`SRFB_OFS_OVFL >> 4)) &
    (req.addr[1:0] == 2'h0);
  assign hit_rx = (req.addr[15:4] == 12'(`SRFB_OFS_RXFLAG >> 4)) &
    (req.addr[1:0] == 2'h0);
  assign hit_ctrl = (req.addr == `SRFB_OFS_CTRL);
  assign hit_stat = (req.addr == `SRFB_OFS_IRQ_STAT);
  assign hit_mask = (req.addr == `SRFB_OFS_IRQ_MASK);

  // =====================================================================
  // segment flag storage
  srfb_pkg::srfb_seg_vec_t irq_en_reg, irq_en_next;
  srfb_pkg::srfb_seg_vec_t rx_reg, rx_next;
  srfb_pkg::srfb_seg_vec_t ov_reg, ov_next;
  srfb_pkg::srfb_seg_vec_t ck_reg, ck_next;
  srfb_pkg::srfb_seg_vec_t wr_vec, rx_clr, en_wmask;
  logic gie_reg, gie_next;

  assign wr_vec = word_to_seg(req.wdata, word_sel);
  assign en_wmask = word_to_seg(32'hffff_ffff, word_sel);
  // one written to receive flag clears it, zero leaves it
  assign rx_clr = (req.wr & hit_rx) ? wr_vec : '0;
  // enable word write touches only the addressed 32 segments
  assign irq_en_next = (req.wr & hit_en) ?
    ((irq_en_reg & ~en_wmask) | wr_vec) : irq_en_reg;
  // set wins over clear
  assign rx_next = (rx_reg & ~rx_clr) | evt.rx;
  // packet on a segment still flagged
  assign ov_next = (ov_reg & ~rx_clr) | (evt.rx & rx_reg);
  assign ck_next = (ck_reg & ~rx_clr) |
    (evt.rx & evt.cksum_err);
  assign gie_next = (req.wr & hit_ctrl) ?
    req.wdata[`SRFB_CTRL_GIE_BIT] : gie_reg;

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      irq_en_reg <= '0;
      rx_reg <= '0;
      ov_reg <= '0;
      ck_reg <= '0;
      gie_reg <= 1'b0;
    end else begin
      irq_en_reg <= irq_en_next;
      rx_reg <= rx_next;
      ov_reg <= ov_next;
      ck_reg <= ck_next;
      gie_reg <= gie_next;
    end
  end

  // =====================================================================
  // segment interrupt combine
  srfb_pkg::srfb_seg_vec_t pending;
  logic buf_req;
  assign pending = rx_reg & irq_en_reg;
  assign buf_req = |pending;
  assign O_SEG_PENDING = pending;
  assign O_BUF_IRQ = buf_req & gie_reg;

  // =====================================================================
  // event status, mask and interrupt output
  logic [2:0] ev_stat_reg, ev_stat_next, ev_mask_reg, ev_mask_next;
  logic [2:0] ev_in, ev_clr;
  assign ev_in[`SRFB_EV_RX_BIT] = O_BUF_IRQ;
  assign ev_in[`SRFB_EV_OVFL_BIT] = |(evt.rx & rx_reg);
  assign ev_in[`SRFB_EV_CKSUM_BIT] = |(evt.rx & evt.cksum_err);
  assign ev_clr = (req.wr & hit_stat) ? req.wdata[2:0] : 3'h0;
  assign ev_stat_next = (ev_stat_reg & ~ev_clr) | ev_in;
  assign ev_mask_next = (req.wr & hit_mask) ? req.wdata[2:0] : ev_mask_reg;

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      ev_stat_reg <= `SRFB_RST_EV;
      ev_mask_reg <= `SRFB_RST_EV;
    end else begin
      ev_stat_reg <= ev_stat_next;
      ev_mask_reg <= ev_mask_next;
    end
  end

  assign O_IRQ = |(ev_stat_reg & ev_mask_reg);

  // =====================================================================
  // read data, one cycle after the strobe
  logic [31:0] rd_mux, rdata_reg;
  assign rd_mux =
    hit_en ? seg_to_word(irq_en_reg, word_sel) :
    hit_ck ? seg_to_word(ck_reg, word_sel) :
    hit_ov ? seg_to_word(ov_reg, word_sel) :
    hit_rx ? seg_to_word(rx_reg, word_sel) :
    hit_ctrl ? {31'h0, gie_reg} :
    hit_stat ? {29'h0, ev_stat_reg} :
    hit_mask ? {29'h0, ev_mask_reg} : `SRFB_RST_WORD;

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      rdata_reg <= `SRFB_RST_WORD;
    end else if (req.rd) begin
      rdata_reg <= rd_mux;
    end else begin
      rdata_reg <= `SRFB_RST_WORD;
    end
  end
  assign O_RDATA = rdata_reg;

  // =====================================================================
  // checks: receive flag set and clear
  chk_rx_set_wins: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RST)
    (I_SEG_RX != '0) |=>
      ((rx_reg & $past(I_SEG_RX)) == $past(I_SEG_RX)))
    else $error("rx set lost");

  chk_rx_sets: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RST)
    (rx_reg & ~$past(rx_reg) & ~$past(I_SEG_RX)) == '0)
    else $error("rx flag set without packet");

  chk_rx_held: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RST)
    !(I_WR && hit_rx) |=> ((rx_reg & $past(rx_reg)) == $past(rx_reg)))
    else $error("rx flag lost");

  chk_rx_w1c: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RST)
    (I_WR && hit_rx) |=>
      ((rx_reg & $past(rx_clr & ~I_SEG_RX)) == '0))
    else $error("w1c failed");

  chk_rx_w0_keep: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RST)
    (I_WR && hit_rx) |=>
      ((rx_reg & $past(rx_reg & ~rx_clr)) == $past(rx_reg & ~rx_clr)))
    else $error("zero write cleared");

  chk_err_clr_same: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RST)
    (I_WR && hit_rx) |=>
      (((ov_reg | ck_reg) & $past(rx_clr & ~I_SEG_RX)) == '0))
    else $error("errors kept");

  // =====================================================================
  // checks: overflow and checksum flags
  chk_ovfl_set: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RST)
    ((I_SEG_RX & rx_reg) != '0) |=>
      ((ov_reg & $past(I_SEG_RX & rx_reg)) == $past(I_SEG_RX & rx_reg)))
    else $error("overflow missed");

  chk_ovfl_first: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RST)
    (ov_reg & ~$past(ov_reg) & ~$past(I_SEG_RX & rx_reg)) == '0)
    else $error("false overflow");

  chk_ovfl_held: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RST)
    !(I_WR && hit_rx) |=> ((ov_reg & $past(ov_reg)) == $past(ov_reg)))
    else $error("overflow flag lost");

  chk_cksum_flag: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RST)
    ((I_SEG_RX & I_SEG_CKSUM_ERR) != '0) |=>
      ((ck_reg & $past(I_SEG_RX & I_SEG_CKSUM_ERR)) ==
        $past(I_SEG_RX & I_SEG_CKSUM_ERR)))
    else $error("checksum error missed");

  chk_cksum_ok: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RST)
    (ck_reg & ~$past(ck_reg) & ~$past(I_SEG_RX & I_SEG_CKSUM_ERR)) == '0)
    else $error("checksum flag spurious");

  chk_cksum_held: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RST)
    !(I_WR && hit_rx) |=> ((ck_reg & $past(ck_reg)) == $past(ck_reg)))
    else $error("checksum flag lost");

  // =====================================================================
  // checks: enables, requests and read data
  chk_en_bit_map: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RST)
    (I_WR && hit_en) |=>
      (irq_en_reg[{$past(word_sel), 5'd0}] == $past(I_WDATA[31])) &&
      (irq_en_reg[{$past(word_sel), 5'd31}] == $past(I_WDATA[0])))
    else $error("enable bit map");

  chk_en_other_words: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RST)
    (I_WR && hit_en) |=>
      (((irq_en_reg ^ $past(irq_en_reg)) & ~$past(en_wmask)) == '0))
    else $error("enable write spilled");

  chk_en_keep: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RST)
    !(I_WR && hit_en) |=> (irq_en_reg == $past(irq_en_reg)))
    else $error("enable changed unwritten");

  chk_rdata_en: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RST)
    (I_RD && hit_en) |=>
      (O_RDATA[0] == $past(irq_en_reg[{word_sel, 5'd31}])))
    else $error("enable read map");

  chk_rdata_rx: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RST)
    (I_RD && hit_rx) |=>
      (O_RDATA[31] == $past(rx_reg[{word_sel, 5'd0}])))
    else $error("rx read map");

  chk_rdata_idle: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RST)
    !I_RD |=> (O_RDATA == '0))
    else $error("read data outside slot");

  chk_seg_irq: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RST)
    O_SEG_PENDING == (rx_reg & irq_en_reg))
    else $error("segment request wrong");

  chk_gie_write: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RST)
    (I_WR && hit_ctrl) |=> (gie_reg == $past(I_WDATA[0])))
    else $error("global enable write");

  chk_gie_gate: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RST)
    !gie_reg |-> !O_BUF_IRQ)
    else $error("ungated irq");

  chk_buf_or: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RST)
    O_BUF_IRQ == (gie_reg && ((rx_reg & irq_en_reg) != '0)))
    else $error("combined request wrong");

  chk_buf_irq_hold: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RST)
    (O_BUF_IRQ && !(I_WR && (hit_rx || hit_en || hit_ctrl))) |=>
      O_BUF_IRQ)
    else $error("combined request dropped");

  // =====================================================================
  // checks: event status
  chk_ev_rx_sticky: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RST)
    O_BUF_IRQ |=> ev_stat_reg[0])
    else $error("request event missed");

  chk_stat_w1c: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RST)
    (I_WR && hit_stat && I_WDATA[0] && !O_BUF_IRQ) |=> !ev_stat_reg[0])
    else $error("status clear failed");

  chk_irq_masked: assert property (
    @(posedge I_SYS_CLK) disable iff (I_RST)
    (ev_mask_reg == 3'h0) |-> !O_IRQ)
    else $error("masked irq raised");

endmodule : srfb_flag_bank
`default_nettype wire

// ==== verification/srfb_flag_bank_tb_top.sv ====
// self-checking bench for the segment flag bank
`default_nettype none
module srfb_flag_bank_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] addr = 16'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_q = 1'b0;
  logic [127:0] seg_rx = '0;
  logic [127:0] seg_ck = '0;
  wire logic [31:0] rdata;
  wire logic [127:0] pend;
  wire logic buf_irq;
  wire logic irq;
  logic [31:0] exp_q[$];
  logic irq_a;
  int err_total = 0;
  int n_checks = 0;
  int s;
  logic [31:0] d;

  always #2.5 clk = ~clk;

  srfb_flag_bank DUT (.I_SYS_CLK(clk), .I_RST(rst), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
    .I_SEG_RX(seg_rx), .I_SEG_CKSUM_ERR(seg_ck), .O_SEG_PENDING(pend),
    .O_BUF_IRQ(buf_irq), .O_IRQ(irq));

  // =====================================================
  // comparison, verdict and watchdog
  task automatic check(input logic [127:0] seen, input logic [127:0] exp,
                       input string what);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results

  initial begin
    #20000;
    err_total++;
    results();
  end

  // =====================================================
  // read data monitor: oldest note against the answer
  always @(posedge clk) rd_q <= rd;
  always @(negedge clk) begin
    if (rd_q)
      check(128'(rdata), 128'(exp_q.pop_front()),
            "rdata");
  end

  // =====================================================
  // drivers
  function automatic logic [15:0] wa(input logic [15:0] b, input int n);
    return b + 16'(4 * (n / 32));
  endfunction : wa

  function automatic logic [31:0] bt(input int n);
    return 32'h8000_0000 >> (n % 32);
  endfunction : bt

  task automatic wr_reg(input logic [15:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [15:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask : rd_reg

  // packet for segment n, optionally with a clear of it in the same cycle
  task automatic seg_evt(input int n, input logic ck, input logic clr);
    @(posedge clk);
    seg_rx <= 128'h1 << n;
    seg_ck <= 128'(ck) << n;
    addr <= wa(16'h8fe0, n);
    wdata <= bt(n);
    wr <= clr;
    @(posedge clk);
    seg_rx <= '0;
    seg_ck <= '0;
    wr <= 1'b0;
  endtask : seg_evt

  // =====================================================
  // tests
  initial begin
    void'($urandom(70185));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 16; i++)
      rd_reg(16'h8f80 + 16'(32 * (i / 4) + 4 * (i % 4)), 32'h0);
    $display("test reset values done");
    for (int w = 0; w < 4; w++) begin
      d = $urandom;
      wr_reg(16'h8f80 + 16'(4 * w), d);
      rd_reg(16'h8f80 + 16'(4 * w), d);
    end
    wr_reg(16'h8fa0, 32'hffff_ffff);
    rd_reg(16'h8fa0, 32'h0);
    rd_reg(16'h8f90, 32'h0);
    $display("test enable words done");
    s = $urandom_range(127);
    wr_reg(wa(16'h8f80, s), 32'hffff_ffff);
    seg_evt(s, 1'b1, 1'b0);
    @(negedge clk);
    check(pend, 128'h1 << s, "pending");
    check(128'(buf_irq), 128'h0, "buf_irq gated");
    wr_reg(16'h8ff0, 32'h1);
    @(negedge clk);
    check(128'(buf_irq), 128'h1, "buf_irq");
    rd_reg(wa(16'h8fe0, s), bt(s));
    rd_reg(wa(16'h8fa0, s), bt(s));
    rd_reg(wa(16'h8fc0, s), 32'h0);
    seg_evt(s, 1'b0, 1'b0);
    rd_reg(wa(16'h8fc0, s), bt(s));
    wr_reg(wa(16'h8fe0, s), ~bt(s));
    rd_reg(wa(16'h8fe0, s), bt(s));
    seg_evt(s, 1'b0, 1'b1);
    rd_reg(wa(16'h8fe0, s), bt(s));
    rd_reg(16'h8ff4, 32'h7);
    $display("test segment flags done");
    wr_reg(16'h8ff8, 32'h7);
    @(negedge clk);
    irq_a = irq;
    wr_reg(16'h8ff8, 32'h0);
    @(negedge clk);
    check(128'(irq ^ irq_a), 128'h1, "irq mask");
    wr_reg(wa(16'h8fe0, s), bt(s));
    for (int i = 0; i < 3; i++)
      rd_reg(wa(16'h8fa0 + 16'(32 * i), s), 32'h0);
    @(negedge clk);
    check(128'(buf_irq), 128'h0, "buf_irq cleared");
    wr_reg(16'h8ff4, 32'h7);
    rd_reg(16'h8ff4, 32'h0);
    @(negedge clk);
    check(128'(irq), 128'h0, "irq cleared");
    $display("test interrupts done");
    repeat (3) @(posedge clk);
    results();
  end
endmodule : srfb_flag_bank_tb_top
`default_nettype wire
